/* design/drive_control_word_decoder.v */
// Purpose: Decodes control words and logic inputs into run and function commands
// Assumes: Control words come from logic on clk_i; logic inputs are pins
// Notes: All outputs registered; one clock, asynchronous active-low reset
`include "drive_ctrl_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module drive_control_word_decoder #(
  parameter NUM_FUNC = 4,
  parameter NUM_LI = `LI_COUNT
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  // Configuration
  input wire profile_select_i,
  input wire run_mode_i,
  input wire combined_command_reference_i,
  input wire [2:0] cmd_channel_i,
  input wire [2:0] ref_channel_i,
  input wire [NUM_FUNC*`CODE_W-1:0] func_code_i,
  // Terminal logic inputs, asynchronous pins
  input wire [NUM_LI:1] logic_input_i,
  // Control words from the network side
  input wire [`WORD_W-1:0] modbus_word_i,
  input wire [`WORD_W-1:0] canopen_word_i,
  input wire [`WORD_W-1:0] netcard_word_i,
  input wire [`WORD_W-1:0] embed_word_i,
  input wire [`WORD_W-1:0] switched_word_i,
  // Decoded commands
  output reg run_fwd_o,
  output reg run_auth_o,
  output reg cmd_via_net_o,
  output reg [1:0] drive_state_o,
  output reg [NUM_FUNC-1:0] func_o
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function [`WORD_W-1:0] chan_word;
    input [2:0] chan;
    input [`WORD_W-1:0] w_mb;
    input [`WORD_W-1:0] w_co;
    input [`WORD_W-1:0] w_nc;
    input [`WORD_W-1:0] w_em;
    begin
      case (chan)
        `CH_MODBUS: chan_word = w_mb;
        `CH_CANOPEN: chan_word = w_co;
        `CH_NETCARD: chan_word = w_nc;
        `CH_EMBED: chan_word = w_em;
        default: chan_word = {`WORD_W{1'b0}};
      endcase
    end
  endfunction

  function is_net_chan;
    input [2:0] chan;
    begin
      is_net_chan = (chan >= `CH_MODBUS) && (chan <= `CH_EMBED);
    end
  endfunction

  // ----------------------------------------
  // Logic input synchroniser
  // ----------------------------------------
  reg [NUM_LI:1] li_s1_q;
  reg [NUM_LI:1] li_s2_q;

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      li_s1_q <= {NUM_LI{1'b0}};
      li_s2_q <= {NUM_LI{1'b0}};
    end else begin
      li_s1_q <= logic_input_i;
      li_s2_q <= li_s1_q;
    end
  end

  // ----------------------------------------
  // Command channel selection
  // ----------------------------------------
  wire [2:0] cmd_chan;
  wire chan_term;
  wire chan_net;
  wire chan_valid;
  wire [`WORD_W-1:0] cmd_word;
  wire run_src;
  wire fwd_src;
  wire std_net;

  // Combined mode takes the command from the reference channel
  assign cmd_chan = combined_command_reference_i ? ref_channel_i : cmd_channel_i;
  assign chan_term = (cmd_chan == `CH_TERM);
  assign chan_net = is_net_chan(cmd_chan);
  assign chan_valid = chan_term | chan_net;
  assign cmd_word = chan_word(cmd_chan, modbus_word_i, canopen_word_i, netcard_word_i, embed_word_i);

  // Same fixed sources whichever side commands
  assign run_src = chan_term ? li_s2_q[`LI_RUN] : cmd_word[`BIT_RUN];
  assign fwd_src = chan_term ? li_s2_q[`LI_FWD] : cmd_word[`BIT_FWD];
  assign std_net = (profile_select_i == `PROF_STD) && chan_net;

  // ----------------------------------------
  // Standardized profile sequence
  // ----------------------------------------
  reg [1:0] state_q;
  reg [1:0] state_d;
  wire cw_on;
  wire cw_volt;
  wire cw_qstop;
  wire cw_op;

  assign cw_on = cmd_word[`STD_SWITCH_ON];
  assign cw_volt = cmd_word[`STD_EN_VOLT];
  assign cw_qstop = cmd_word[`STD_QSTOP];
  assign cw_op = cmd_word[`STD_EN_OP];

  always @* begin
    state_d = state_q;
    if (!std_net) begin
      state_d = `ST_DISABLED;
    end else if (!cw_volt || !cw_qstop) begin
      state_d = `ST_DISABLED;
    end else begin
      case (state_q)
        `ST_DISABLED: begin
          if (!cw_on) begin
            state_d = `ST_READY;
          end
        end
        `ST_READY: begin
          if (cw_on) begin
            state_d = `ST_SWON;
          end
        end
        `ST_SWON: begin
          if (!cw_on) begin
            state_d = `ST_READY;
          end else if (cw_op) begin
            state_d = `ST_ENABLED;
          end
        end
        `ST_ENABLED: begin
          if (!cw_on) begin
            state_d = `ST_READY;
          end else if (!cw_op) begin
            state_d = `ST_SWON;
          end
        end
        default: begin
          state_d = `ST_DISABLED;
        end
      endcase
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= `ST_DISABLED;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Edge run latch
  // ----------------------------------------
  reg fwd_prev_q;
  reg fwd_latch_q;
  reg fwd_latch_d;
  wire fwd_rise;

  assign fwd_rise = fwd_src & ~fwd_prev_q;

  always @* begin
    fwd_latch_d = fwd_latch_q;
    if (!chan_valid || run_mode_i != `MODE_EDGE || std_net) begin
      fwd_latch_d = 1'b0;
    end else if (!run_src) begin
      fwd_latch_d = 1'b0;
    end else if (fwd_rise) begin
      fwd_latch_d = 1'b1;
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fwd_prev_q <= 1'b0;
      fwd_latch_q <= 1'b0;
    end else begin
      fwd_prev_q <= fwd_src;
      fwd_latch_q <= fwd_latch_d;
    end
  end

  // ----------------------------------------
  // Run decode
  // ----------------------------------------
  reg run_d;
  reg auth_d;

  always @* begin
    run_d = 1'b0;
    auth_d = 1'b0;
    if (!chan_valid) begin
      run_d = 1'b0;
      auth_d = 1'b0;
    end else if (std_net) begin
      run_d = (state_d == `ST_ENABLED);
      auth_d = run_d;
    end else if (run_mode_i == `MODE_EDGE) begin
      auth_d = run_src;
      run_d = run_src & fwd_latch_d;
    end else begin
      auth_d = run_src;
      run_d = run_src;
    end
  end

  // ----------------------------------------
  // Function inputs
  // ----------------------------------------
  wire [NUM_FUNC-1:0] func_sel;

  genvar g;
  generate
    for (g = 0; g < NUM_FUNC; g = g + 1) begin : g_func
      source_select #(
        .NUM_LI(NUM_LI)
      ) u_source_select (
        .code_i(func_code_i[g*`CODE_W +: `CODE_W]),
        .profile_i(profile_select_i),
        .run_mode_i(run_mode_i),
        .li_i(li_s2_q),
        .modbus_word_i(modbus_word_i),
        .canopen_word_i(canopen_word_i),
        .netcard_word_i(netcard_word_i),
        .embed_word_i(embed_word_i),
        .switched_word_i(switched_word_i),
        .bit_o(func_sel[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_fwd_o <= 1'b0;
      run_auth_o <= 1'b0;
      cmd_via_net_o <= 1'b0;
      drive_state_o <= `ST_DISABLED;
      func_o <= {NUM_FUNC{1'b0}};
    end else begin
      run_fwd_o <= run_d;
      run_auth_o <= auth_d;
      cmd_via_net_o <= chan_net;
      drive_state_o <= state_d;
      func_o <= chan_valid ? func_sel : {NUM_FUNC{1'b0}};
    end
  end

endmodule // drive_control_word_decoder

`default_nettype wire

/* design/drive_ctrl_defs.vh */
// Purpose: Constants for the drive control word decoder
// Assumes: Included by design files by bare name
// Notes: Assignment code = {1'b0, source kind[2:0], bit index[3:0]}
//
// Functional notes
// - Terminal profile: run starts motor immediately
// - Terminal profile: all 16 word bits usable
// - Standard profile: only bits 11-15 assignable
// - Standard profile: run needs command sequence on network channels; terminals run directly
// - Separate and combined command/reference modes
// - Same behaviour from network or terminals, except the standard profile sequence gates network only
// - Network bit code: channel plus index
// - Functions assignable to terminal inputs 2-14 (3-14 in edge mode)
// - Functions assignable to switched bits 0-15
// - Level mode: forward fixed to input1/bit0
// - Level mode: run while source is one
// - Level mode: bits 1-15 freely assignable
// - Edge mode: stop fixed to input1/bit0
// - Edge mode: forward fixed to input2/bit1
// - Edge mode: forward on rising edge, authorised
// - Edge mode: bits 2-15 freely assignable
// - Code selects source, e.g. CANopen bit 1
// - Terminals and all words usable together
`ifndef DRIVE_CTRL_DEFS_VH
`define DRIVE_CTRL_DEFS_VH

// ----------------------------------------
// Profile and run scheme
// ----------------------------------------
`define PROF_IO 1'b0
`define PROF_STD 1'b1
`define MODE_LEVEL 1'b0
`define MODE_EDGE 1'b1

// ----------------------------------------
// Active command channel
// ----------------------------------------
`define CH_NONE 3'h0
`define CH_TERM 3'h1
`define CH_MODBUS 3'h2
`define CH_CANOPEN 3'h3
`define CH_NETCARD 3'h4
`define CH_EMBED 3'h5

// ----------------------------------------
// Assignment code layout and source kinds
// ----------------------------------------
`define CODE_W 8
`define CODE_KIND_HI 6
`define CODE_KIND_LO 4
`define CODE_IDX_HI 3
`define CODE_IDX_LO 0
`define SRC_NONE 3'h0
`define SRC_MODBUS 3'h1
`define SRC_CANOPEN 3'h2
`define SRC_NETCARD 3'h3
`define SRC_EMBED 3'h4
`define SRC_TERM 3'h5
`define SRC_SWITCHED 3'h6

// ----------------------------------------
// Index limits
// ----------------------------------------
`define NET_MIN_LEVEL 4'h1
`define NET_MIN_EDGE 4'h2
`define NET_MIN_STD 4'hB
`define TERM_MIN_LEVEL 4'h2
`define TERM_MIN_EDGE 4'h3
`define TERM_MAX 4'hE

// ----------------------------------------
// Fixed bits and inputs
// ----------------------------------------
`define WORD_W 16
`define LI_COUNT 14
`define BIT_RUN 0
`define BIT_FWD 1
`define LI_RUN 1
`define LI_FWD 2

// ----------------------------------------
// Standardized word bits and states
// ----------------------------------------
`define STD_SWITCH_ON 0
`define STD_EN_VOLT 1
`define STD_QSTOP 2
`define STD_EN_OP 3
`define ST_DISABLED 2'h0
`define ST_READY 2'h1
`define ST_SWON 2'h2
`define ST_ENABLED 2'h3

`endif

/* design/source_select.v */
// Purpose: Picks one function input from its assignment code
// Assumes: Inputs already synchronised; purely combinational
// Notes: Codes outside the allowed index range give zero
`include "drive_ctrl_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module source_select #(
  parameter NUM_LI = `LI_COUNT
) (
  // Assignment and configuration
  input wire [`CODE_W-1:0] code_i,
  input wire profile_i,
  input wire run_mode_i,
  // Sources
  input wire [NUM_LI:1] li_i,
  input wire [`WORD_W-1:0] modbus_word_i,
  input wire [`WORD_W-1:0] canopen_word_i,
  input wire [`WORD_W-1:0] netcard_word_i,
  input wire [`WORD_W-1:0] embed_word_i,
  input wire [`WORD_W-1:0] switched_word_i,
  // Result
  output reg bit_o
);

  wire [2:0] kind;
  wire [3:0] idx;
  reg [3:0] net_min;
  reg [3:0] term_min;
  reg [`WORD_W-1:0] word;

  assign kind = code_i[`CODE_KIND_HI:`CODE_KIND_LO];
  assign idx = code_i[`CODE_IDX_HI:`CODE_IDX_LO];

  always @* begin
    // Lowest usable word bit depends on profile and scheme
    if (profile_i == `PROF_STD) begin
      net_min = `NET_MIN_STD;
    end else if (run_mode_i == `MODE_EDGE) begin
      net_min = `NET_MIN_EDGE;
    end else begin
      net_min = `NET_MIN_LEVEL;
    end
    term_min = (run_mode_i == `MODE_EDGE) ? `TERM_MIN_EDGE : `TERM_MIN_LEVEL;
    word = {`WORD_W{1'b0}};
    bit_o = 1'b0;
    case (kind)
      `SRC_MODBUS: word = modbus_word_i;
      `SRC_CANOPEN: word = canopen_word_i;
      `SRC_NETCARD: word = netcard_word_i;
      `SRC_EMBED: word = embed_word_i;
      default: word = {`WORD_W{1'b0}};
    endcase
    case (kind)
      `SRC_MODBUS, `SRC_CANOPEN, `SRC_NETCARD, `SRC_EMBED: begin
        bit_o = (idx >= net_min) ? word[idx] : 1'b0;
      end
      `SRC_TERM: begin
        bit_o = (idx >= term_min && idx <= `TERM_MAX) ? li_i[idx] : 1'b0;
      end
      `SRC_SWITCHED: begin
        bit_o = switched_word_i[idx];
      end
      default: begin
        bit_o = 1'b0;
      end
    endcase
  end

endmodule // source_select

`default_nettype wire

/* dv/drive_control_word_decoder_properties.sv */
// Purpose: Port assertions for the control word decoder
// Assumes: Bound into every decoder instance
// Notes: Terminal-sourced functions are left to the bench
`include "drive_ctrl_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module decoder_props #(
  parameter NUM_FUNC = 4,
  parameter NUM_LI = `LI_COUNT
) (
  // Clock, reset, configuration
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic profile_select_i,
  input wire logic run_mode_i,
  input wire logic combined_command_reference_i,
  input wire logic [2:0] cmd_channel_i,
  input wire logic [2:0] ref_channel_i,
  input wire logic [NUM_FUNC*`CODE_W-1:0] func_code_i,
  input wire logic [NUM_LI:1] logic_input_i,
  // Words
  input wire logic [`WORD_W-1:0] modbus_word_i,
  input wire logic [`WORD_W-1:0] canopen_word_i,
  input wire logic [`WORD_W-1:0] netcard_word_i,
  input wire logic [`WORD_W-1:0] embed_word_i,
  input wire logic [`WORD_W-1:0] switched_word_i,
  // Commands
  input wire logic run_fwd_o,
  input wire logic run_auth_o,
  input wire logic cmd_via_net_o,
  input wire logic [1:0] drive_state_o,
  input wire logic [NUM_FUNC-1:0] func_o
);
  wire [2:0] ch = combined_command_reference_i ? ref_channel_i : cmd_channel_i;
  wire ok = ch != 3'h0 && ch < 3'h6;
  wire net = ok && ch != 3'h1;
  wire [63:0] nw = {embed_word_i, netcard_word_i, canopen_word_i, modbus_word_i};
  wire [1:0] wi = ch[1:0] + 2'h2;
  wire [15:0] w = nw[16*wi +: 16];
  wire io_lvl = !profile_select_i && !run_mode_i && net;
  wire io_edg = !profile_select_i && run_mode_i && net;
  wire [7:0] c = func_code_i[7:0];
  wire [3:0] lo = profile_select_i ? 4'hB : run_mode_i ? 4'h2 : 4'h1;
  wire [1:0] ci = c[5:4] - 2'h1;
  wire f0 = c[6:4] == 3'h6 ? switched_word_i[c[3:0]] :
    (c[6:4] != 3'h0 && c[6:4] < 3'h5 && c[3:0] >= lo) ? nw[{ci, c[3:0]}] : 1'b0;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_idle_all_low: assert property (!ok |=>
    !run_fwd_o && !run_auth_o && !cmd_via_net_o && drive_state_o == 2'h0 && func_o == '0) else $error("idle");
  a_level_run: assert property (io_lvl |=> run_fwd_o == $past(w[0]))
    else $error("level run");
  a_edge_rise: assert property (io_edg && $stable(ch) && $stable(run_mode_i) &&
    w[1:0] == 2'h3 && !$past(w[1]) |=> run_fwd_o) else $error("edge rise");
  a_edge_hold: assert property (io_edg && $stable(ch) && $stable(run_mode_i) &&
    $past(rst_b_i) && !run_fwd_o && $past(w[1]) |=> !run_fwd_o) else $error("edge level");
  a_stop_clears: assert property (io_edg && !w[0] |=> !run_fwd_o && !run_auth_o)
    else $error("stop");
  a_std_gate: assert property (profile_select_i && net |=> !run_fwd_o || drive_state_o == 2'h3)
    else $error("std run");
  a_func_source: assert property (net && c[6:4] != 3'h5 |=> func_o[0] == $past(f0))
    else $error("function");
  a_term_run: assert property ((ch == 3'h1 && !run_mode_i && logic_input_i[1]) [*4] |=> run_fwd_o)
    else $error("terminal run");

  c_std_run: cover property (drive_state_o == 2'h3 && run_fwd_o);
  c_edge_run: cover property (io_edg && run_fwd_o);
  c_term_run: cover property (ch == 3'h1 && run_fwd_o);
endmodule // decoder_props

bind drive_control_word_decoder decoder_props #(.NUM_FUNC(NUM_FUNC), .NUM_LI(NUM_LI)) u_props (.*);
`default_nettype wire

/* dv/net_master_model.sv */
// Purpose: Network master writing the four control words
// Assumes: Bench hands it the next words as one request
// Notes: Words change only just after a clock edge
`timescale 1ns/1ps
`default_nettype none

module net_master_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Requested words, Modbus lowest
  input wire logic [63:0] word_req_i,
  // Words seen by the drive
  output logic [63:0] word_o
);
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      word_o <= 64'h0;
    end else begin
      word_o <= word_req_i;
    end
  end
endmodule // net_master_model
`default_nettype wire

/* dv/test_drive_control_word_decoder.sv */
// Purpose: Self-checking bench for the control word decoder
// Assumes: Network words pass through the master model
// Notes: Expected results queued, compared by a monitor
`timescale 1ns/1ps
`default_nettype none
`define CMP(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; $display("[FAIL] %0t differ", $time); end end

module test_drive_control_word_decoder;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic prof = 1'b0;
  logic mode = 1'b0;
  logic comb = 1'b0;
  logic [2:0] cmd_ch = 3'h0;
  logic [2:0] ref_ch = 3'h0;
  logic [31:0] fcode = 32'h6F3F2141;
  logic [14:1] li = 14'h0;
  logic [63:0] req = 64'h0;
  logic [63:0] w;
  logic [15:0] sw = 16'h0;
  logic [15:0] ws;
  logic [31:0] seed = 32'h421C5B1E;
  logic [8:0] mask;
  logic [8:0] want;
  logic [17:0] notes [$];
  logic [17:0] item;
  logic smp = 1'b0;
  logic seen = 1'b0;
  logic [3:0] ew [7] = '{4'h5, 4'hF, 4'h8, 4'hD, 4'h5, 4'hF, 4'h0};
  logic [19:0] sq [5] = '{20'h00010, 20'h00061, 20'h00072, 20'h000F7, 20'h000D0};
  wire [63:0] nw;
  wire [8:0] outs;
  int mismatches = 0;
  int check_count = 0;
  int i;
  int k;

  always #5 clk_i = ~clk_i;

  drive_control_word_decoder DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .profile_select_i(prof),
    .run_mode_i(mode), .combined_command_reference_i(comb), .cmd_channel_i(cmd_ch), .ref_channel_i(ref_ch),
    .func_code_i(fcode), .logic_input_i(li), .modbus_word_i(nw[15:0]), .canopen_word_i(nw[31:16]),
    .netcard_word_i(nw[47:32]), .embed_word_i(nw[63:48]), .switched_word_i(sw), .run_fwd_o(outs[8]),
    .run_auth_o(outs[7]), .cmd_via_net_o(outs[6]), .drive_state_o(outs[5:4]), .func_o(outs[3:0]));
  net_master_model u_master (.clk_i(clk_i), .rst_b_i(rst_b_i), .word_req_i(req), .word_o(nw));

  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic setw(input [63:0] v, input int n);
    req <= v;
    wait_clk(n);
  endtask

  task automatic expect_out(input [8:0] m, input [8:0] v);
    notes.push_back({m, v});
    smp <= ~smp;
    wait_clk(1);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(negedge clk_i) begin
    if (smp != seen) begin
      seen = smp;
      item = notes.pop_front();
      `CMP(outs & item[17:9], item[8:0] & item[17:9])
    end
  end

  initial begin
    wait_clk(1000);
    mismatches++;
    report_and_stop;
  end

  initial begin
    wait_clk(6);
    rst_b_i <= 1'b1;
    setw(64'hFFFFFFFFFFFFFFFF, 3);
    expect_out(9'h1FF, 9'h000);
    for (i = 0; i < 12; i++) begin
      k = i % 3;
      seed = lfsr(seed);
      w[31:0] = seed;
      seed = lfsr(seed);
      w[63:32] = seed;
      seed = lfsr(seed);
      if (k == 1) w = w & ~(64'h2 << (16 * (i / 3)));
      ws = w[16 * (i / 3) +: 16];
      setw(w, 1);
      prof <= (k == 2);
      mode <= (k == 1);
      comb <= i[0];
      cmd_ch <= i[0] ? 3'h0 : 3'(2 + i / 3);
      ref_ch <= i[0] ? 3'(2 + i / 3) : 3'h7;
      sw <= seed[15:0];
      wait_clk(3);
      mask = k == 0 ? 9'h14F : k == 1 ? 9'h0CF : 9'h04F;
      want = {k == 0 && ws[0], k == 1 && ws[0], 3'h4, seed[15], w[47], k == 0 && w[17], k == 0 && w[49]};
      expect_out(mask, want);
    end
    setw(64'h0, 2);
    prof <= 1'b0;
    mode <= 1'b1;
    comb <= 1'b0;
    cmd_ch <= 3'h2;
    foreach (ew[j]) begin
      setw({62'h0, ew[j][3:2]}, 3);
      expect_out(9'h180, {ew[j][1:0], 7'h00});
    end
    prof <= 1'b1;
    mode <= 1'b0;
    cmd_ch <= 3'h3;
    foreach (sq[j]) begin
      setw({32'h0, sq[j][19:4], 16'h0}, 3);
      expect_out(9'h130, {sq[j][2], 2'b00, sq[j][1:0], 4'h0});
    end
    prof <= 1'b0;
    fcode <= 32'h6F3F2152;
    cmd_ch <= 3'h1;
    li <= 14'h0003;
    wait_clk(5);
    expect_out(9'h1C1, 9'h181);
    mode <= 1'b1;
    li <= 14'h0001;
    wait_clk(5);
    li <= 14'h0003;
    wait_clk(5);
    expect_out(9'h1C1, 9'h180);
    cmd_ch <= 3'h6;
    wait_clk(3);
    expect_out(9'h1FF, 9'h000);
    report_and_stop;
  end
endmodule // test_drive_control_word_decoder
`default_nettype wire
